// ===== adc_cfg_chk_props.sv
`timescale 1ns/1ns
module adc_cfg_chk (
    input wire CLK,
    input wire RST,
    input wire REG_WRITE,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    input wire CHANNEL_SELECT,
    input wire BUILTIN_SELF_TEST_START,
    input wire SELF_TEST_REINIT,
    input wire OUTPUT_STANDARD_18V,
    input wire [15:0] FINE_DELAY_PS,
    input wire [7:0] PATTERN_ONE_LOW_BYTE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // ----------------------------------------
    // Quiet cycle after a write, so a rewrite cannot mask the copy
    // ----------------------------------------
    sequence s_w(a);
        REG_WRITE && REG_ADDR == a ##1 !(REG_WRITE && REG_ADDR == a);
    endsequence
    property p_start; s_w(8'h0E) |=> BUILTIN_SELF_TEST_START == $past(REG_WDATA[0], 2); endproperty
    a_start: assert property (p_start) else $error("start");
    property p_reinit; s_w(8'h0E) |=> SELF_TEST_REINIT == $past(REG_WDATA[2], 2); endproperty
    a_reinit: assert property (p_reinit) else $error("reinit");
    property p_delay;
        s_w(8'h17) |=> FINE_DELAY_PS == 16'h0230 * ({13'h0000, $past(REG_WDATA[2:0], 2)} + 16'h0001);
    endproperty
    a_delay: assert property (p_delay) else $error("delay");
    property p_pat; s_w(8'h19) |=> PATTERN_ONE_LOW_BYTE == $past(REG_WDATA, 2); endproperty
    a_pat: assert property (p_pat) else $error("pattern");
    property p_std;
        REG_WRITE && REG_ADDR == 8'h14 && !CHANNEL_SELECT ##1 !(REG_WRITE && REG_ADDR == 8'h14)
            |=> OUTPUT_STANDARD_18V == ($past(REG_WDATA[7:6], 2) == 2'h2);
    endproperty
    a_std: assert property (p_std) else $error("standard");
    property p_trim;
        REG_WRITE && REG_ADDR == 8'h10 ##1 REG_ADDR == 8'h10 && $stable(CHANNEL_SELECT) |-> REG_RDATA == $past(REG_WDATA);
    endproperty
    a_trim: assert property (p_trim) else $error("trim");
    property p_rst; $fell(RST) && REG_ADDR == 8'h15 |-> REG_RDATA == 8'h22; endproperty
    a_rst: assert property (p_rst) else $error("drive reset");
    property p_rdpat; REG_WRITE && REG_ADDR == 8'h19 ##1 REG_ADDR == 8'h19 |-> REG_RDATA == $past(REG_WDATA); endproperty
    a_rdpat: assert property (p_rdpat) else $error("pattern read");
    c_delay: cover property (s_w(8'h17));
    c_std: cover property (OUTPUT_STANDARD_18V);
    c_rst: cover property ($fell(RST));
endmodule
bind adc_output_config_regs adc_cfg_chk chk (.CLK, .RST, .REG_WRITE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .CHANNEL_SELECT, .BUILTIN_SELF_TEST_START, .SELF_TEST_REINIT, .OUTPUT_STANDARD_18V, .FINE_DELAY_PS,
    .PATTERN_ONE_LOW_BYTE);

// ===== adc_out_cfg_map.vh
// What this block does
// - Setting bit 0 of self-test control starts self-test; bit 2 re-initialises it.
// - Per-channel eight-bit twos complement offset trim, +127 to -128, resets to zero.
// - Format field 00 offset binary, 01 twos complement; invert bit flips output data.
// - Two-bit output standard field: 00 gives 3.3 V, 10 gives 1.8 V.
// - Two-bit drive fields for data and clock per supply; one to four stripes; reset 0x22.
// - Three-bit phase field delays output clock by 0 to 7 input clock cycles.
// - Phase picks divider output phase for the output clock; sampling is untouched.
// - Enabled fine delay on data and/or clock, codes 0..7 give 0.56 to 4.48 ns.
// - Low byte of first user test pattern held in its own register, reset zero.
`ifndef ADC_OUT_CFG_MAP_VH
`define ADC_OUT_CFG_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SELF_TEST 8'h0E
`define OFS_OFFSET_TRIM 8'h10
`define OFS_FORMAT 8'h14
`define OFS_DRIVE 8'h15
`define OFS_PHASE 8'h16
`define OFS_FINE_DELAY 8'h17
`define OFS_PATTERN_ONE_LOW 8'h19
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SELF_TEST 8'h00
`define RST_OFFSET_TRIM 8'h00
`define RST_FORMAT 8'h00
`define RST_DRIVE 8'h22
`define RST_PHASE 8'h00
`define RST_FINE_DELAY 8'h00
`define RST_PATTERN_ONE_LOW 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_SELF_TEST_START 0
`define BIT_SELF_TEST_REINIT 2
`define FLD_FMT_CODE 1:0
`define BIT_INVERT 2
`define FLD_STANDARD 7:6
`define FLD_DATA_DRV_18 1:0
`define FLD_DATA_DRV_33 3:2
`define FLD_CLK_DRV_18 5:4
`define FLD_CLK_DRV_33 7:6
`define FLD_PHASE 2:0
`define BIT_CLK_POLARITY 7
`define FLD_DELAY_CODE 2:0
`define BIT_DATA_DELAY_EN 5
`define BIT_CLK_DELAY_EN 7
// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define FMT_OFFSET_BINARY 2'h0
`define FMT_TWOS 2'h1
`define STD_33V 2'h0
`define STD_18V 2'h2
`define DELAY_STEP_PS 16'h0230
`endif

// ===== adc_output_config_regs.v
`timescale 1ns/1ns
`include "adc_out_cfg_map.vh"
module adc_output_config_regs #(
    parameter SAMPLE_WIDTH = 14
) (
    input wire CLK,
    input wire RST,
    input wire REG_WRITE,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    input wire CHANNEL_SELECT,
    input wire [SAMPLE_WIDTH-1:0] SAMPLE_A,
    input wire [SAMPLE_WIDTH-1:0] SAMPLE_B,
    input wire DIVIDED_CLOCK,
    output reg [SAMPLE_WIDTH-1:0] DATA_OUT_A,
    output reg [SAMPLE_WIDTH-1:0] DATA_OUT_B,
    output wire OUTPUT_DATA_CLOCK,
    output reg BUILTIN_SELF_TEST_START,
    output reg SELF_TEST_REINIT,
    output reg OUTPUT_STANDARD_18V,
    output reg [1:0] DATA_STRIPES,
    output reg [1:0] CLOCK_STRIPES,
    output reg DATA_DELAY_ENABLE,
    output reg CLOCK_DELAY_ENABLE,
    output reg [15:0] FINE_DELAY_PS,
    output reg [7:0] PATTERN_ONE_LOW_BYTE
);
    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // Per-channel registers are indexed by the channel select
    reg [7:0] self_test_control;
    reg [7:0] offset_trim [0:1];
    reg [7:0] output_format_control [0:1];
    reg [7:0] output_drive_strength;
    reg [7:0] output_clock_phase [0:1];
    reg [7:0] output_fine_delay;
    reg [7:0] user_pattern_one_low;
    wire ch = CHANNEL_SELECT;

    // Trim, convert format, then invert
    function [SAMPLE_WIDTH-1:0] shape;
        input [SAMPLE_WIDTH-1:0] raw;
        input [7:0] trim;
        input [7:0] fmt;
        reg [SAMPLE_WIDTH-1:0] trimmed;
        begin
            trimmed = raw + {{(SAMPLE_WIDTH-8){trim[7]}}, trim};
            if (fmt[`FLD_FMT_CODE] == `FMT_TWOS)
                trimmed = {~trimmed[SAMPLE_WIDTH-1], trimmed[SAMPLE_WIDTH-2:0]};
            if (fmt[`BIT_INVERT])
                trimmed = ~trimmed;
            shape = trimmed;
        end
    endfunction

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            self_test_control <= `RST_SELF_TEST;
            offset_trim[0] <= `RST_OFFSET_TRIM;
            offset_trim[1] <= `RST_OFFSET_TRIM;
            output_format_control[0] <= `RST_FORMAT;
            output_format_control[1] <= `RST_FORMAT;
            output_drive_strength <= `RST_DRIVE;
            output_clock_phase[0] <= `RST_PHASE;
            output_clock_phase[1] <= `RST_PHASE;
            output_fine_delay <= `RST_FINE_DELAY;
            user_pattern_one_low <= `RST_PATTERN_ONE_LOW;
        end else if (REG_WRITE) begin
            // Unmapped offsets fall to the default and are dropped silently
            case (REG_ADDR)
                `OFS_SELF_TEST: self_test_control <= REG_WDATA;
                `OFS_OFFSET_TRIM: offset_trim[ch] <= REG_WDATA;
                `OFS_FORMAT: output_format_control[ch] <= REG_WDATA;
                `OFS_DRIVE: output_drive_strength <= REG_WDATA;
                `OFS_PHASE: output_clock_phase[ch] <= REG_WDATA;
                `OFS_FINE_DELAY: output_fine_delay <= REG_WDATA;
                `OFS_PATTERN_ONE_LOW: user_pattern_one_low <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    always @* begin
        case (REG_ADDR)
            `OFS_SELF_TEST: REG_RDATA = self_test_control;
            `OFS_OFFSET_TRIM: REG_RDATA = offset_trim[ch];
            `OFS_FORMAT: REG_RDATA = output_format_control[ch];
            `OFS_DRIVE: REG_RDATA = output_drive_strength;
            `OFS_PHASE: REG_RDATA = output_clock_phase[ch];
            `OFS_FINE_DELAY: REG_RDATA = output_fine_delay;
            `OFS_PATTERN_ONE_LOW: REG_RDATA = user_pattern_one_low;
            // Unmapped offsets read as zero
            default: REG_RDATA = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Output decode helpers
    // ----------------------------------------
    // Only the pair of stripe codes for the live supply reaches the drivers
    function [1:0] pick_stripes;
        input low_supply;
        input [1:0] code_18;
        input [1:0] code_33;
        begin
            if (low_supply)
                pick_stripes = code_18;
            else
                pick_stripes = code_33;
        end
    endfunction

    // One step more than the code, so code 0 is still one step of delay
    function [15:0] delay_ps;
        input [2:0] code;
        begin
            delay_ps = ({13'h0000, code} + 16'h0001) * `DELAY_STEP_PS;
        end
    endfunction

    // ----------------------------------------
    // Next values of the outputs
    // ----------------------------------------
    reg [SAMPLE_WIDTH-1:0] next_data_out_a;
    reg [SAMPLE_WIDTH-1:0] next_data_out_b;
    reg next_self_test_start;
    reg next_self_test_reinit;
    reg next_standard_18v;
    reg [1:0] next_data_stripes;
    reg [1:0] next_clock_stripes;
    reg next_data_delay_enable;
    reg next_clock_delay_enable;
    reg [15:0] next_fine_delay_ps;
    reg [7:0] next_pattern_one_low_byte;

    always @* begin
        // Both channels share one path; only their stored trim and format differ
        next_data_out_a = shape(SAMPLE_A, offset_trim[0], output_format_control[0]);
        next_data_out_b = shape(SAMPLE_B, offset_trim[1], output_format_control[1]);
        // Levels, not pulses: the self-test engine decides when a run is over
        next_self_test_start = self_test_control[`BIT_SELF_TEST_START];
        next_self_test_reinit = self_test_control[`BIT_SELF_TEST_REINIT];
        // Only code 10 selects the low supply; other codes fall back to 3.3 V
        next_standard_18v = (output_format_control[0][`FLD_STANDARD] == `STD_18V);
        // Stripe count minus one follows the active supply level
        next_data_stripes = pick_stripes(next_standard_18v, output_drive_strength[`FLD_DATA_DRV_18],
            output_drive_strength[`FLD_DATA_DRV_33]);
        next_clock_stripes = pick_stripes(next_standard_18v, output_drive_strength[`FLD_CLK_DRV_18],
            output_drive_strength[`FLD_CLK_DRV_33]);
        // Enables are passed on as stored and the code is turned into picoseconds; the pads apply the delay
        next_data_delay_enable = output_fine_delay[`BIT_DATA_DELAY_EN];
        next_clock_delay_enable = output_fine_delay[`BIT_CLK_DELAY_EN];
        next_fine_delay_ps = delay_ps(output_fine_delay[`FLD_DELAY_CODE]);
        next_pattern_one_low_byte = user_pattern_one_low;
    end

    // ----------------------------------------
    // Sample outputs
    // ----------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            DATA_OUT_A <= {SAMPLE_WIDTH{1'b0}};
            DATA_OUT_B <= {SAMPLE_WIDTH{1'b0}};
        end else begin
            DATA_OUT_A <= next_data_out_a;
            DATA_OUT_B <= next_data_out_b;
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    // Registered so the pads see one clean change per write, never a decode glitch
    always @(posedge CLK) begin
        if (RST) begin
            BUILTIN_SELF_TEST_START <= 1'b0;
            SELF_TEST_REINIT <= 1'b0;
            OUTPUT_STANDARD_18V <= 1'b0;
            DATA_STRIPES <= 2'h0;
            CLOCK_STRIPES <= 2'h0;
            DATA_DELAY_ENABLE <= 1'b0;
            CLOCK_DELAY_ENABLE <= 1'b0;
            FINE_DELAY_PS <= 16'h0000;
            PATTERN_ONE_LOW_BYTE <= 8'h00;
        end else begin
            BUILTIN_SELF_TEST_START <= next_self_test_start;
            SELF_TEST_REINIT <= next_self_test_reinit;
            OUTPUT_STANDARD_18V <= next_standard_18v;
            DATA_STRIPES <= next_data_stripes;
            CLOCK_STRIPES <= next_clock_stripes;
            DATA_DELAY_ENABLE <= next_data_delay_enable;
            CLOCK_DELAY_ENABLE <= next_clock_delay_enable;
            FINE_DELAY_PS <= next_fine_delay_ps;
            PATTERN_ONE_LOW_BYTE <= next_pattern_one_low_byte;
        end
    end

    // ----------------------------------------
    // Output clock phase
    // ----------------------------------------
    // Phase and polarity come from channel A; channel B copies are stored and read back only
    // Sample path above never looks at the phase, so internal latching is unaffected
    clock_phase_select #(
        .DEPTH(8)
    ) phase_sel (
        .CLK(CLK),
        .RST(RST),
        .div_clk(DIVIDED_CLOCK),
        .phase(output_clock_phase[0][`FLD_PHASE]),
        .invert(output_clock_phase[0][`BIT_CLK_POLARITY]),
        .out_clk(OUTPUT_DATA_CLOCK)
    );
endmodule

// ===== clock_phase_select.v
`timescale 1ns/1ns
// Picks one of eight phases of the divided clock by delaying it whole cycles
module clock_phase_select #(
    parameter DEPTH = 8
) (
    input wire CLK,
    input wire RST,
    input wire div_clk,
    input wire [2:0] phase,
    input wire invert,
    output reg out_clk
);
    // The undelayed phase needs no tap, so one flop fewer than phases
    reg [DEPTH-2:0] taps;

    always @(posedge CLK) begin
        if (RST) begin
            taps <= {(DEPTH-1){1'b0}};
            out_clk <= 1'b0;
        end else begin
            taps <= {taps[DEPTH-3:0], div_clk};
            // Phase 0 takes the undelayed clock
            out_clk <= ((phase == 3'h0) ? div_clk : taps[phase - 3'h1]) ^ invert;
        end
    end
endmodule

// ===== test_adc_output_config_regs.sv
`timescale 1ns/1ns
module test_adc_output_config_regs;
    reg CLK = 1'b0;
    reg RST = 1'b1;
    reg REG_WRITE = 1'b0;
    reg [7:0] REG_ADDR = 8'h15;
    reg [7:0] REG_WDATA = 8'h00;
    reg CHANNEL_SELECT = 1'b0;
    reg DIVIDED_CLOCK = 1'b0;
    reg [13:0] SAMPLE = 14'h1000;
    wire [7:0] REG_RDATA, PATTERN_ONE_LOW_BYTE;
    wire [13:0] DATA_OUT_A, DATA_OUT_B;
    wire [15:0] FINE_DELAY_PS;
    wire [1:0] DATA_STRIPES, CLOCK_STRIPES;
    wire OUTPUT_DATA_CLOCK, BUILTIN_SELF_TEST_START, SELF_TEST_REINIT, OUTPUT_STANDARD_18V;
    wire DATA_DELAY_ENABLE, CLOCK_DELAY_ENABLE;
    integer failures = 0;
    integer checks_done = 0;
    integer i, l0, l7;
    reg [55:0] offs = {8'h0E, 8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19};
    adc_output_config_regs uut (.CLK, .RST, .REG_WRITE, .REG_ADDR, .REG_WDATA, .REG_RDATA, .CHANNEL_SELECT,
        .SAMPLE_A(SAMPLE), .SAMPLE_B(SAMPLE), .DIVIDED_CLOCK, .DATA_OUT_A, .DATA_OUT_B, .OUTPUT_DATA_CLOCK,
        .BUILTIN_SELF_TEST_START, .SELF_TEST_REINIT, .OUTPUT_STANDARD_18V, .DATA_STRIPES, .CLOCK_STRIPES,
        .DATA_DELAY_ENABLE, .CLOCK_DELAY_ENABLE, .FINE_DELAY_PS, .PATTERN_ONE_LOW_BYTE);
    initial begin
        forever #2 CLK = ~CLK;
    end
    // ----------------------------------------
    // Access tasks: drive 1 ns after the edge, n idle edges after a write
    // ----------------------------------------
    task chk(input [63:0] name, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d, input ch, input integer n);
        begin
            {REG_WRITE, REG_ADDR, REG_WDATA, CHANNEL_SELECT} = {1'b1, a, d, ch};
            @(posedge CLK);
            #1;
            if (n > 0) REG_WRITE = 1'b0;
            repeat (n) @(posedge CLK);
            if (n > 0) #1;
        end
    endtask
    task rd(input [7:0] a, input ch, input [7:0] e);
        begin
            {REG_WRITE, REG_ADDR, CHANNEL_SELECT} = {1'b0, a, ch};
            #2;
            chk("rdata", e, REG_RDATA);
            @(posedge CLK);
            #1;
        end
    endtask
    task lat(output integer n);
        begin
            DIVIDED_CLOCK = ~DIVIDED_CLOCK;
            n = 0;
            while (OUTPUT_DATA_CLOCK !== DIVIDED_CLOCK && n < 40) begin
                @(posedge CLK);
                #1;
                n = n + 1;
            end
            if (n == 40) begin
                failures = failures + 1;
                final_report;
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge CLK);
        #1;
        RST = 1'b0;
        for (i = 0; i < 7; i = i + 1) begin
            rd(offs[i*8+:8], 1'b0, offs[i*8+:8] == 8'h15 ? 8'h22 : 8'h00);
        end
        rd(8'h11, 1'b0, 8'h00);
        chk("stripes", 4'h0, {DATA_STRIPES, CLOCK_STRIPES});
        wr(8'h0E, 8'h05, 1'b0, 2);
        chk("selftest", 2'h3, {SELF_TEST_REINIT, BUILTIN_SELF_TEST_START});
        wr(8'h0E, 8'h01, 1'b0, 0);
        wr(8'h10, 8'h80, 1'b1, 0);
        wr(8'h10, 8'h7F, 1'b0, 0);
        rd(8'h10, 1'b0, 8'h7F);
        rd(8'h10, 1'b1, 8'h80);
        chk("selftest", 2'h1, {SELF_TEST_REINIT, BUILTIN_SELF_TEST_START});
        chk("out_a", 14'h107F, DATA_OUT_A);
        chk("out_b", 14'h0F80, DATA_OUT_B);
        wr(8'h14, 8'h01, 1'b0, 0);
        wr(8'h14, 8'h04, 1'b1, 2);
        chk("out_a", 14'h307F, DATA_OUT_A);
        chk("out_b", 14'h307F, DATA_OUT_B);
        wr(8'h14, 8'h81, 1'b0, 2);
        chk("stripes", 5'h1A, {OUTPUT_STANDARD_18V, DATA_STRIPES, CLOCK_STRIPES});
        wr(8'h15, 8'hE4, 1'b0, 0);
        wr(8'h14, 8'h01, 1'b0, 2);
        chk("stripes", 5'h07, {OUTPUT_STANDARD_18V, DATA_STRIPES, CLOCK_STRIPES});
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h17, 8'hA0 | i[7:0], 1'b0, 2);
            chk("delay", 16'h0230 * (i[15:0] + 16'h0001), FINE_DELAY_PS);
        end
        wr(8'h17, 8'h20, 1'b0, 0);
        wr(8'h19, 8'hA5, 1'b0, 0);
        rd(8'h19, 1'b0, 8'hA5);
        chk("delay_en", 2'h2, {DATA_DELAY_ENABLE, CLOCK_DELAY_ENABLE});
        chk("pattern", 8'hA5, PATTERN_ONE_LOW_BYTE);
        lat(l0);
        wr(8'h16, 8'h07, 1'b0, 12);
        lat(l7);
        chk("phase", 16'h0007, l7 - l0);
        wr(8'h16, 8'h87, 1'b0, 12);
        chk("clk", {15'h0000, ~DIVIDED_CLOCK}, OUTPUT_DATA_CLOCK);
        DIVIDED_CLOCK = ~DIVIDED_CLOCK;
        repeat (9) @(posedge CLK);
        #1;
        chk("clk", {15'h0000, ~DIVIDED_CLOCK}, OUTPUT_DATA_CLOCK);
        chk("out_a", 14'h307F, DATA_OUT_A);
        SAMPLE = 14'h2000;
        wr(8'h14, 8'h42, 1'b0, 2);
        chk("out_a", 14'h207F, DATA_OUT_A);
        chk("out_b", 14'h207F, DATA_OUT_B);
        chk("std", 16'h0000, OUTPUT_STANDARD_18V);
        RST = 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        RST = 1'b0;
        rd(8'h15, 1'b0, 8'h22);
        chk("pattern", 8'h00, PATTERN_ONE_LOW_BYTE);
        final_report;
    end
endmodule
